// [testbench.sv]
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk_sys_i = 1'b0;
   logic                  rstn_i = 1'b0;
   logic                  ce_i = 1'b1;
   logic                  fp_emulation_bit_i = 1'b0;
   logic                  os_vector_state_save_enable_i = 1'b1;
   logic                  vector_ext_feature_flag_i = 1'b1;
   logic                  pfx_valid_i, op_valid_i, op_has_mem_i, out_valid_o, invalid_op_o;
   logic                  reserved_o, addr_size_o, rep_alt_op_o, multi_pfx_o;
   logic [7:0]            pfx_byte_i, exc_vector_o;
   logic [2:0]            seg_sel_o;
   logic [31:0]           feature_edx_o;
   vpx_pkg::vpx_class_e   op_class_i;
   vpx_pkg::vpx_verdict_e verdict_o;
   int                    err_total = 0;
   int                    cmp_count = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   vpx_fetch_model vpx_fetch_model_i (.clk_sys_i, .pfx_valid_o(pfx_valid_i), .pfx_byte_o(pfx_byte_i),
      .op_valid_o(op_valid_i), .op_class_o(op_class_i), .op_has_mem_o(op_has_mem_i));
   vpx_decode vpx_decode_i (.clk_sys_i, .rstn_i, .ce_i, .pfx_valid_i, .pfx_byte_i, .op_valid_i, .op_class_i,
      .op_has_mem_i, .fp_emulation_bit_i, .os_vector_state_save_enable_i, .vector_ext_feature_flag_i,
      .out_valid_o, .verdict_o, .invalid_op_o, .exc_vector_o, .reserved_o, .multi_pfx_o, .addr_size_o,
      .seg_sel_o, .rep_alt_op_o, .feature_edx_o);
   // -------------------------------------------------------------
   // shared helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic vpx_pkg::vpx_verdict_e vd(input logic ok);
      return ok ? vpx_pkg::VPX_OUT_EXEC : vpx_pkg::VPX_OUT_INVALID_OP;
   endfunction
   task automatic run(input logic [15:0] p, input int unsigned n, input vpx_pkg::vpx_class_e c, input logic m,
                      input vpx_pkg::vpx_verdict_e v, input logic a, input logic [2:0] s, input logic r);
      logic bad;
      bad = v == vpx_pkg::VPX_OUT_INVALID_OP;
      vpx_fetch_model_i.send(p, n, c, m);
      chk(out_valid_o, 1'b1);
      chk(verdict_o, v);
      chk(invalid_op_o, bad);
      chk(exc_vector_o, bad ? 8'h06 : 8'h00);
      chk(reserved_o, v == vpx_pkg::VPX_OUT_RESERVED);
      chk(addr_size_o, a);
      chk(seg_sel_o, s);
      chk(rep_alt_op_o, r);
      chk(multi_pfx_o, 1'b0);
   endtask
   task automatic ctl(input logic e, input logic o, input logic f);
      @(negedge clk_sys_i);
      fp_emulation_bit_i = e;
      os_vector_state_save_enable_i = o;
      vector_ext_feature_flag_i = f;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic sc_reset();
      chk(out_valid_o, 1'b0);
      chk(verdict_o, vd(1'b1));
      chk(feature_edx_o, 32'h02000000);
   endtask
   task automatic sc_lock();
      for (int c = 1; c <= 5; c++) begin
         run(16'h00f0, 1, vpx_pkg::vpx_class_e'(c), 1'(c), vd(1'b0), 1'b0, 3'h0, 1'b0);
      end
   endtask
   task automatic sc_addr_seg();
      logic [7:0] sb [6] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65};
      int         cl [3] = '{1, 3, 4};
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 12; i++) begin
            run({sb[i % 6], 8'h67}, 2, vpx_pkg::vpx_class_e'(cl[k]), 1'(i / 6), vd(1'b1),
                1'(i / 6), (i < 6) ? 3'h0 : 3'(i - 5), 1'b0);
         end
      end
   endtask
   task automatic sc_reserved();
      logic [7:0] rb [3] = '{8'h66, 8'hf3, 8'hf2};
      logic       alt;
      for (int c = 1; c <= 5; c++) begin
         for (int j = 0; j < 3; j++) begin
            alt = c == 1 && j == 1;
            run({8'h00, rb[j]}, 1, vpx_pkg::vpx_class_e'(c), 1'b0,
                alt ? vd(1'b1) : vpx_pkg::VPX_OUT_RESERVED, 1'b0, 3'h0, alt);
         end
      end
   endtask
   task automatic sc_gating();
      logic e, o, f;
      for (int g = 0; g < 8; g++) begin
         {e, o, f} = 3'(g);
         ctl(e, o, f);
         run(16'h0000, 0, vpx_pkg::VPX_CLS_PACKED_FP, 1'b1, vd(!e && o && f), 1'b0, 3'h0, 1'b0);
         run(16'h0000, 0, vpx_pkg::VPX_CLS_ADDED_INT, 1'b1, vd(!e && f), 1'b0, 3'h0, 1'b0);
         run(16'h0000, 0, vpx_pkg::VPX_CLS_PREFETCH_FENCE, 1'b1, vd(f), 1'b0, 3'h0, 1'b0);
         run(16'h0000, 0, vpx_pkg::VPX_CLS_CACHE_CTRL, 1'b1, vd(!e && f), 1'b0, 3'h0, 1'b0);
         run(16'h0000, 0, vpx_pkg::VPX_CLS_FEATURE_QUERY, 1'b0, vd(1'b1), 1'b0, 3'h0, 1'b0);
         chk(feature_edx_o, {6'h00, f, 25'h0000000});
      end
   endtask
   task automatic sc_freeze();
      ctl(1'b0, 1'b1, 1'b1);
      ce_i = 1'b0;
      vpx_fetch_model_i.send(16'h00f0, 1, vpx_pkg::VPX_CLS_PACKED_FP, 1'b0);
      chk(out_valid_o, 1'b0);
      chk(verdict_o, vd(1'b1));
      ce_i = 1'b1;
      run(16'h0000, 0, vpx_pkg::VPX_CLS_PACKED_FP, 1'b0, vd(1'b1), 1'b0, 3'h0, 1'b0);
   endtask
   task automatic sc_mid_reset();
      run({8'h65, 8'h67}, 2, vpx_pkg::VPX_CLS_PACKED_FP, 1'b1, vd(1'b1), 1'b1, 3'h6, 1'b0);
      rstn_i = 1'b0;
      @(negedge clk_sys_i);
      chk(addr_size_o, 1'b0);
      chk(seg_sel_o, 3'h0);
      chk(feature_edx_o, 32'h00000000);
      rstn_i = 1'b1;
      @(negedge clk_sys_i);
      chk(feature_edx_o, 32'h02000000);
      run(16'h00f3, 1, vpx_pkg::VPX_CLS_PACKED_FP, 1'b0, vd(1'b1), 1'b0, 3'h0, 1'b1);
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rstn_i = 1'b1;
      @(negedge clk_sys_i);
      sc_reset();
      sc_lock();
      sc_addr_seg();
      sc_reserved();
      sc_gating();
      sc_freeze();
      sc_mid_reset();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire

// [vpx_decode.sv]
// Behaviour
// RULE_01 - packed fp: address-size and segment prefixes apply to memory forms only
// RULE_02 - packed fp: repeat prefix is significant and selects an alternate operation
// RULE_03 - packed fp: operand-size and repeat-not-equal prefixes are reserved
// RULE_04 - lock prefix on packed fp or added integer raises invalid opcode
// RULE_05 - added integer: addr/segment on memory forms; 66, f3, f2 reserved
// RULE_06 - cache control: addr/segment on memory forms; 66, f3, f2 reserved
// RULE_07 - lock prefix on any cache control instruction raises invalid opcode
// RULE_08 - two prefixes of one group are undefined; stream must avoid them
// RULE_09 - logic, move, shuffle and state-save group: rep, repne, 66 reserved
// RULE_10 - packed fp runs only if emulation 0, state-save enable 1, feature 1
// RULE_11 - identification query reports the feature flag in bit 25 of edx
// RULE_12 - added integer faults on emulation bit, not on state-save enable
// RULE_13 - prefetch and store fence depend only on the feature flag
`include "vpx_params.svh"
`default_nettype none

module vpx_decode #(
   parameter int unsigned SEG_W = 3
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 rstn_i,
   input  wire logic                 ce_i,
   // prefix bytes, one per cycle, ahead of the opcode
   input  wire logic                 pfx_valid_i,
   input  wire logic [7:0]           pfx_byte_i,
   // opcode strobe closes the instruction
   input  wire logic                 op_valid_i,
   input  wire vpx_pkg::vpx_class_e  op_class_i,
   input  wire logic                 op_has_mem_i,
   // architectural controls
   input  wire logic                 fp_emulation_bit_i,
   input  wire logic                 os_vector_state_save_enable_i,
   input  wire logic                 vector_ext_feature_flag_i,
   // to execute / exception units
   output logic                      out_valid_o,
   output vpx_pkg::vpx_verdict_e     verdict_o,
   output logic                      invalid_op_o,
   output logic [7:0]                exc_vector_o,
   output logic                      reserved_o,
   output logic                      multi_pfx_o,
   output logic                      addr_size_o,
   output logic [SEG_W-1:0]          seg_sel_o,
   output logic                      rep_alt_op_o,
   output logic [31:0]               feature_edx_o
);

   // ---------------------------------------------------------------
   // prefix classification
   // ---------------------------------------------------------------
   logic       s_addr;
   logic       s_opnd;
   logic [2:0] s_seg;
   logic       s_rep;
   logic       s_repne;
   logic       s_lock;

   vpx_prefix_scan u_scan (
      .byte_i     (pfx_byte_i),
      .valid_i    (pfx_valid_i),
      .is_addr_o  (s_addr),
      .is_opnd_o  (s_opnd),
      .seg_o      (s_seg),
      .is_rep_o   (s_rep),
      .is_repne_o (s_repne),
      .is_lock_o  (s_lock)
   );

   // ---------------------------------------------------------------
   // prefix accumulation
   // ---------------------------------------------------------------
   logic             acc_addr;
   logic             acc_opnd;
   logic [SEG_W-1:0] acc_seg;
   logic             acc_rep;
   logic             acc_repne;
   logic             acc_lock;
   logic             acc_dup;
   logic             next_acc_addr;
   logic             next_acc_opnd;
   logic [SEG_W-1:0] next_acc_seg;
   logic             next_acc_rep;
   logic             next_acc_repne;
   logic             next_acc_lock;
   logic             next_acc_dup;

   // groups: lock/rep/repne, segment, operand size, address size
   function automatic logic dup_hit(input logic grp1_seen, input logic seg_seen,
                                    input logic opnd_seen, input logic addr_seen,
                                    input logic grp1_new, input logic seg_new,
                                    input logic opnd_new, input logic addr_new);
      dup_hit = (grp1_seen && grp1_new) || (seg_seen && seg_new) ||
                (opnd_seen && opnd_new) || (addr_seen && addr_new);
   endfunction

   always_comb begin
      next_acc_addr  = acc_addr;
      next_acc_opnd  = acc_opnd;
      next_acc_seg   = acc_seg;
      next_acc_rep   = acc_rep;
      next_acc_repne = acc_repne;
      next_acc_lock  = acc_lock;
      next_acc_dup   = acc_dup;
      if (op_valid_i) begin
         // opcode ends the instruction; a prefix in the same cycle is ignored
         next_acc_addr  = 1'b0;
         next_acc_opnd  = 1'b0;
         next_acc_seg   = SEG_W'(`VPX_NO_SEG);
         next_acc_rep   = 1'b0;
         next_acc_repne = 1'b0;
         next_acc_lock  = 1'b0;
         next_acc_dup   = 1'b0;
      end else if (pfx_valid_i) begin
         // duplicates are only flagged: the outcome is left undefined [RULE_08]
         next_acc_dup = acc_dup ||
                        dup_hit(acc_lock || acc_rep || acc_repne, acc_seg != SEG_W'(`VPX_NO_SEG),
                                acc_opnd, acc_addr, s_lock || s_rep || s_repne,
                                s_seg != `VPX_NO_SEG, s_opnd, s_addr);
         next_acc_addr  = acc_addr | s_addr;
         next_acc_opnd  = acc_opnd | s_opnd;
         next_acc_rep   = acc_rep | s_rep;
         next_acc_repne = acc_repne | s_repne;
         next_acc_lock  = acc_lock | s_lock;
         if (s_seg != `VPX_NO_SEG) begin
            next_acc_seg = SEG_W'(s_seg);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_addr  <= 1'b0;
         acc_opnd  <= 1'b0;
         acc_seg   <= '0;
         acc_rep   <= 1'b0;
         acc_repne <= 1'b0;
         acc_lock  <= 1'b0;
         acc_dup   <= 1'b0;
      end else if (ce_i) begin
         acc_addr  <= next_acc_addr;
         acc_opnd  <= next_acc_opnd;
         acc_seg   <= next_acc_seg;
         acc_rep   <= next_acc_rep;
         acc_repne <= next_acc_repne;
         acc_lock  <= next_acc_lock;
         acc_dup   <= next_acc_dup;
      end
   end

   // ---------------------------------------------------------------
   // verdict
   // ---------------------------------------------------------------
   logic                  en_ok;
   logic                  lock_bad;
   logic                  rsv;
   logic                  mem_pfx;
   logic                  rep_alt;
   logic                  next_out_valid;
   vpx_pkg::vpx_verdict_e next_verdict;
   logic                  next_addr_size;
   logic [SEG_W-1:0]      next_seg_sel;
   logic                  next_rep_alt;
   logic                  next_multi;

   // packed fp needs all three controls; the integer side ignores state-save enable
   function automatic logic fp_enabled(input logic emu,
                                       input logic save_en,
                                       input logic feat);
      fp_enabled = !emu && save_en && feat;
   endfunction

   function automatic logic int_enabled(input logic emu,
                                        input logic feat);
      int_enabled = !emu && feat;
   endfunction

   // repeat selects an operation only where the class allows it, elsewhere it is reserved
   function automatic logic rsv_hit(input logic opnd,
                                    input logic rep,
                                    input logic repne,
                                    input logic rep_legal);
      rsv_hit = opnd || repne || (rep && !rep_legal);
   endfunction

   // the pulse outputs share one test: a live answer of one kind
   function automatic logic pulse_of(input logic                  live,
                                     input vpx_pkg::vpx_verdict_e got,
                                     input vpx_pkg::vpx_verdict_e kind);
      pulse_of = live && (got == kind);
   endfunction

   always_comb begin
      en_ok    = 1'b1;
      lock_bad = 1'b0;
      rsv      = 1'b0;
      mem_pfx  = 1'b0;
      rep_alt  = 1'b0;
      unique case (op_class_i)
         vpx_pkg::VPX_CLS_PACKED_FP: begin
            en_ok    = fp_enabled(fp_emulation_bit_i, os_vector_state_save_enable_i,
                                  vector_ext_feature_flag_i);                 // [RULE_10]
            lock_bad = acc_lock;                                              // [RULE_04]
            rsv      = rsv_hit(acc_opnd, acc_rep, acc_repne, 1'b1);           // [RULE_03]
            mem_pfx  = op_has_mem_i;                                          // [RULE_01]
            rep_alt  = acc_rep;                                               // [RULE_02]
         end
         vpx_pkg::VPX_CLS_PACKED_FP_NOREP: begin
            en_ok    = fp_enabled(fp_emulation_bit_i, os_vector_state_save_enable_i,
                                  vector_ext_feature_flag_i);                 // [RULE_10]
            lock_bad = acc_lock;                                              // [RULE_04]
            rsv      = rsv_hit(acc_opnd, acc_rep, acc_repne, 1'b0);           // [RULE_09]
            mem_pfx  = op_has_mem_i;                                          // [RULE_01]
         end
         vpx_pkg::VPX_CLS_ADDED_INT: begin
            en_ok    = int_enabled(fp_emulation_bit_i, vector_ext_feature_flag_i); // [RULE_12]
            lock_bad = acc_lock;                                              // [RULE_04]
            rsv      = rsv_hit(acc_opnd, acc_rep, acc_repne, 1'b0);           // [RULE_05]
            mem_pfx  = op_has_mem_i;                                          // [RULE_05]
         end
         vpx_pkg::VPX_CLS_CACHE_CTRL: begin
            en_ok    = int_enabled(fp_emulation_bit_i, vector_ext_feature_flag_i); // [RULE_12]
            lock_bad = acc_lock;                                              // [RULE_07]
            rsv      = rsv_hit(acc_opnd, acc_rep, acc_repne, 1'b0);           // [RULE_06]
            mem_pfx  = op_has_mem_i;                                          // [RULE_06]
         end
         vpx_pkg::VPX_CLS_PREFETCH_FENCE: begin
            en_ok    = vector_ext_feature_flag_i;                             // [RULE_13]
            lock_bad = acc_lock;                                              // [RULE_07]
            rsv      = rsv_hit(acc_opnd, acc_rep, acc_repne, 1'b0);           // [RULE_06]
            mem_pfx  = op_has_mem_i;                                          // [RULE_06]
         end
         default: begin
            // non-vector classes pass untouched
            en_ok = 1'b1;
         end
      endcase

      next_out_valid = op_valid_i;
      next_verdict   = verdict_o;
      next_addr_size = addr_size_o;
      next_seg_sel   = seg_sel_o;
      next_rep_alt   = rep_alt_op_o;
      next_multi     = multi_pfx_o;
      if (op_valid_i) begin
         // lock and enable faults outrank the reserved flag: the fault is architectural
         if (lock_bad || !en_ok) begin
            next_verdict = vpx_pkg::VPX_OUT_INVALID_OP;                        // [RULE_04]
         end else if (rsv) begin
            next_verdict = vpx_pkg::VPX_OUT_RESERVED;                          // [RULE_03]
         end else begin
            next_verdict = vpx_pkg::VPX_OUT_EXEC;
         end
         // register-only forms drop the address and segment prefixes
         next_addr_size = mem_pfx && acc_addr;                                 // [RULE_01]
         next_seg_sel   = mem_pfx ? acc_seg : SEG_W'(`VPX_NO_SEG);             // [RULE_01]
         next_rep_alt   = rep_alt;                                             // [RULE_02]
         next_multi     = acc_dup;                                             // [RULE_08]
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_valid_o   <= 1'b0;
         verdict_o     <= vpx_pkg::VPX_OUT_EXEC;
         invalid_op_o  <= 1'b0;
         exc_vector_o  <= 8'h00;
         reserved_o    <= 1'b0;
         multi_pfx_o   <= 1'b0;
         addr_size_o   <= 1'b0;
         seg_sel_o     <= '0;
         rep_alt_op_o  <= 1'b0;
         feature_edx_o <= 32'h0000_0000;
      end else if (ce_i) begin
         out_valid_o   <= next_out_valid;
         verdict_o     <= next_verdict;
         invalid_op_o  <= pulse_of(next_out_valid, next_verdict, vpx_pkg::VPX_OUT_INVALID_OP);
         exc_vector_o  <= pulse_of(next_out_valid, next_verdict, vpx_pkg::VPX_OUT_INVALID_OP)
                          ? `VPX_INVALID_OP_VEC : 8'h00;
         reserved_o    <= pulse_of(next_out_valid, next_verdict, vpx_pkg::VPX_OUT_RESERVED);
         multi_pfx_o   <= next_multi;
         addr_size_o   <= next_addr_size;
         seg_sel_o     <= next_seg_sel;
         rep_alt_op_o  <= next_rep_alt;
         // query result: only the feature bit is owned here
         feature_edx_o <= 32'(vector_ext_feature_flag_i) << `VPX_FEAT_BIT_POS;  // [RULE_11]
      end
   end

endmodule

`default_nettype wire

// [vpx_decode_props.sv]
`default_nettype none
module vpx_decode_chk (
   input wire logic                  clk_sys_i,
   input wire logic                  rstn_i,
   input wire logic                  ce_i,
   input wire logic                  pfx_valid_i,
   input wire logic [7:0]            pfx_byte_i,
   input wire logic                  op_valid_i,
   input wire vpx_pkg::vpx_class_e   op_class_i,
   input wire logic                  fp_emulation_bit_i,
   input wire logic                  os_vector_state_save_enable_i,
   input wire logic                  vector_ext_feature_flag_i,
   input wire logic                  out_valid_o,
   input wire vpx_pkg::vpx_verdict_e verdict_o,
   input wire logic                  invalid_op_o,
   input wire logic [7:0]            exc_vector_o,
   input wire logic                  reserved_o,
   input wire logic                  rep_alt_op_o,
   input wire logic [31:0]           feature_edx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // -------------------------------------------------------------
   // prefixes seen since the last opcode: lock, rep, repne, opnd, addr
   // -------------------------------------------------------------
   logic [4:0]      seen;
   logic [4:0]      next_seen;
   wire logic [7:0] b = pfx_byte_i;
   wire logic       feat = vector_ext_feature_flag_i;
   wire logic       en = !fp_emulation_bit_i && os_vector_state_save_enable_i && feat;
   wire logic       fp = op_class_i == vpx_pkg::VPX_CLS_PACKED_FP;
   wire logic       resc = op_class_i inside {[vpx_pkg::VPX_CLS_PACKED_FP_NOREP:vpx_pkg::VPX_CLS_PREFETCH_FENCE]};
   wire logic       lockc = op_class_i inside {[vpx_pkg::VPX_CLS_PACKED_FP:vpx_pkg::VPX_CLS_PREFETCH_FENCE]};
   // two prefixes of one group are left unjudged, their outcome is open
   wire logic       rsv = en && (fp ? seen[2:1] != 2'h0 : resc && seen[3:1] != 3'h0);
   always_comb begin
      next_seen = seen;
      if (ce_i && op_valid_i) next_seen = 5'h00;
      else if (ce_i && pfx_valid_i) next_seen = seen | {b == 8'hf0, b == 8'hf3, b == 8'hf2, b == 8'h66, b == 8'h67};
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) seen <= 5'h00;
      else seen <= next_seen;
   end
   sequence s_take;
      ce_i && op_valid_i;
   endsequence
   sequence s_free;
      s_take ##0 !seen[4];
   endsequence
   AST_ANSWER: assert property (s_take |=> out_valid_o)
      else $error("opcode got no answer");
   AST_LOCK: assert property (s_take ##0 (seen[4] && seen[3:2] == 2'h0 && lockc) |=>
      invalid_op_o && exc_vector_o == 8'h06) else $error("lock prefix did not fault");
   AST_FP_GATE: assert property (s_free ##0 (fp && !en) |=> invalid_op_o)
      else $error("disabled packed fp did not fault");
   AST_INT_EMU: assert property (s_free ##0 (op_class_i == vpx_pkg::VPX_CLS_ADDED_INT) |=>
      invalid_op_o == ($past(fp_emulation_bit_i) || !$past(feat))) else $error("added integer gating wrong");
   AST_PF_FEAT: assert property (s_free ##0 (op_class_i == vpx_pkg::VPX_CLS_PREFETCH_FENCE) |=>
      invalid_op_o == !$past(feat)) else $error("prefetch gating wrong");
   AST_REP_ALT: assert property (s_take ##0 (fp && en && seen == 5'h08) |=>
      rep_alt_op_o && verdict_o == vpx_pkg::VPX_OUT_EXEC) else $error("repeat prefix not applied");
   AST_RESV: assert property (s_free ##0 rsv |=> reserved_o && !invalid_op_o)
      else $error("reserved prefix not flagged");
   AST_FEAT_BIT: assert property ($past(rstn_i) && $past(ce_i) |->
      feature_edx_o == {6'h00, $past(feat), 25'h0000000}) else $error("feature bit wrong");
endmodule
bind vpx_decode vpx_decode_chk vpx_decode_chk_i (.clk_sys_i, .rstn_i, .ce_i, .pfx_valid_i, .pfx_byte_i,
   .op_valid_i, .op_class_i, .fp_emulation_bit_i, .os_vector_state_save_enable_i, .vector_ext_feature_flag_i,
   .out_valid_o, .verdict_o, .invalid_op_o, .exc_vector_o, .reserved_o, .rep_alt_op_o, .feature_edx_o);
`default_nettype wire

// [vpx_fetch_model.sv]
`default_nettype none
module vpx_fetch_model (
   input  wire logic                clk_sys_i,
   output var logic                 pfx_valid_o,
   output var logic [7:0]           pfx_byte_o,
   output var logic                 op_valid_o,
   output var vpx_pkg::vpx_class_e  op_class_o,
   output var logic                 op_has_mem_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pfx_valid_o = 1'b0;
      pfx_byte_o = 8'h00;
      op_valid_o = 1'b0;
      op_class_o = vpx_pkg::VPX_CLS_NONE;
      op_has_mem_o = 1'b0;
   end
   // -------------------------------------------------------------
   // one instruction: n prefixes, lowest byte first, then the opcode
   // -------------------------------------------------------------
   // callers pass at most one prefix per group reserved ones only on purpose
   task automatic send(input logic [15:0] pfx, input int unsigned n, input vpx_pkg::vpx_class_e cls,
                       input logic mem);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys_i);
         pfx_valid_o = 1'b1;
         pfx_byte_o = pfx[8*i +: 8];
      end
      @(negedge clk_sys_i);
      pfx_valid_o = 1'b0;
      // a released lane flips so a stale prefix cannot pass for a live one
      pfx_byte_o = ~pfx_byte_o;
      op_valid_o = 1'b1;
      op_class_o = cls;
      op_has_mem_o = mem;
      @(negedge clk_sys_i);
      op_valid_o = 1'b0;
      op_has_mem_o = ~mem;
   endtask
endmodule
`default_nettype wire

// [vpx_params.svh]
`ifndef VPX_PARAMS_SVH
`define VPX_PARAMS_SVH

// ---------------------------------------------------------------
// prefix byte encodings
// ---------------------------------------------------------------
`define VPX_PFX_ADDR_SIZE   8'h67
`define VPX_PFX_OPND_SIZE   8'h66
`define VPX_PFX_SEG_CS      8'h2e
`define VPX_PFX_SEG_SS      8'h36
`define VPX_PFX_SEG_DS      8'h3e
`define VPX_PFX_SEG_ES      8'h26
`define VPX_PFX_SEG_FS      8'h64
`define VPX_PFX_SEG_GS      8'h65
`define VPX_PFX_REP         8'hf3
`define VPX_PFX_REPNE       8'hf2
`define VPX_PFX_LOCK        8'hf0

// ---------------------------------------------------------------
// control bit positions and exception vector
// ---------------------------------------------------------------
`define VPX_EMU_BIT_POS     2
`define VPX_SAVE_EN_BIT_POS 9
`define VPX_FEAT_BIT_POS    25
`define VPX_INVALID_OP_VEC  8'h06
`define VPX_NO_SEG          3'h0

`endif

// [vpx_pkg.sv]
`default_nettype none

package vpx_pkg;

   // instruction class supplied by the fetch stage
   typedef enum logic [2:0] {
      VPX_CLS_NONE,
      VPX_CLS_PACKED_FP,
      VPX_CLS_PACKED_FP_NOREP,
      VPX_CLS_ADDED_INT,
      VPX_CLS_CACHE_CTRL,
      VPX_CLS_PREFETCH_FENCE,
      VPX_CLS_FEATURE_QUERY
   } vpx_class_e;

   typedef enum logic [1:0] {
      VPX_OUT_EXEC,
      VPX_OUT_INVALID_OP,
      VPX_OUT_RESERVED
   } vpx_verdict_e;

endpackage

`default_nettype wire

// [vpx_prefix_scan.sv]
`include "vpx_params.svh"
`default_nettype none

// ---------------------------------------------------------------
// combinational classification of one prefix byte per cycle
// ---------------------------------------------------------------
module vpx_prefix_scan (
   input  wire logic [7:0] byte_i,
   input  wire logic       valid_i,
   output logic            is_addr_o,
   output logic            is_opnd_o,
   output logic [2:0]      seg_o,
   output logic            is_rep_o,
   output logic            is_repne_o,
   output logic            is_lock_o
);

   always_comb begin
      is_addr_o  = valid_i && (byte_i == `VPX_PFX_ADDR_SIZE);
      is_opnd_o  = valid_i && (byte_i == `VPX_PFX_OPND_SIZE);
      is_rep_o   = valid_i && (byte_i == `VPX_PFX_REP);
      is_repne_o = valid_i && (byte_i == `VPX_PFX_REPNE);
      is_lock_o  = valid_i && (byte_i == `VPX_PFX_LOCK);
      seg_o      = `VPX_NO_SEG;
      if (valid_i) begin
         unique case (byte_i)
            `VPX_PFX_SEG_ES: seg_o = 3'h1;
            `VPX_PFX_SEG_CS: seg_o = 3'h2;
            `VPX_PFX_SEG_SS: seg_o = 3'h3;
            `VPX_PFX_SEG_DS: seg_o = 3'h4;
            `VPX_PFX_SEG_FS: seg_o = 3'h5;
            `VPX_PFX_SEG_GS: seg_o = 3'h6;
            default:         seg_o = `VPX_NO_SEG;
         endcase
      end
   end

endmodule

`default_nettype wire
